// File: hdl/timer8.sv
// 8-bit timer/counter: clock select, compare channels, flags, AXI4-Lite.
// Assumes inputs synchronous to aclk and at most one write and one read
// under way at a time.
//
// Functional notes
// - Force bits strobe compare, non-PWM modes only
// - Forced compare sets no flag, no clear
// - Force bits always read back zero
// - Reserved bits read zero, written zero
// - Clock select: stop, prescaled, external edges
// - External pin counts even when an output
// - Counter readable and writable directly
// - Counter write blocks next timer-clock match
// - Compare registers continuously compared with counter
// - Interrupt needs enable, global enable, flag
// - Match flags set on counter equal compare
// - Overflow flag set on counter overflow
// - Vector execution clears its own flag
// - Writing one clears a flag bit
// - Mode bits choose where overflow sets
`timescale 1ns/100ps
module timer8 (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [7:0] awaddr,
  input  wire logic       awvalid,
  output logic            awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0] wstrb,
  input  wire logic       wvalid,
  output logic            wready,
  output logic [1:0]      bresp,
  output logic            bvalid,
  input  wire logic       bready,
  input  wire logic [7:0] araddr,
  input  wire logic       arvalid,
  output logic            arready,
  output logic [31:0]     rdata,
  output logic [1:0]      rresp,
  output logic            rvalid,
  input  wire logic       rready,
  input  wire logic       external_count_pin,
  input  wire timer8_pkg::irq_bits_type vector_done,
  output logic            wave_out_a,
  output logic            wave_out_b,
  output logic            irq
);
  import timer8_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  control_a_type ctrl_a;
  control_b_type ctrl_b;
  logic [7:0]    count_value;
  logic [7:0]    compare_value_a;
  logic [7:0]    compare_value_b;
  irq_bits_type  interrupt_mask;
  irq_bits_type  interrupt_flags;
  logic          global_irq_enable;
  logic [9:0]    prescale;
  logic          pin_prev;
  logic          count_down;
  logic          block_match;
  logic          aw_full;
  logic          w_full;
  logic [5:0]    aw_index;
  logic [31:0]   w_data;
  logic          w_lane0;

  // Waveform output step for one channel
  // Outside PWM: action 01 toggles, 1x sets or clears on a hit.
  // Fast PWM: 1x acts on the hit and the inverse at bottom.
  // Phase correct: the hit acts one way up and the other way down.
  // Action 01 in PWM toggles only where the caller allows it.
  // Action 00 leaves the output where it stands.
  function automatic logic wave_next(
    input logic       cur,
    input logic [1:0] act,
    input logic       hit,
    input logic       bottom,
    input logic       down,
    input logic       pwm,
    input logic       can_toggle
  );
    logic v;
    v = cur;
    if (!pwm) begin
      if (hit && act == 2'h1) begin
        v = ~cur;
      end else if (hit && act[1]) begin
        v = act[0];
      end
    end else if (act[1]) begin
      if (hit) begin
        v = act[0] ^ down;
      end else if (bottom) begin
        v = ~act[0];
      end
    end else if (act[0] && can_toggle && hit) begin
      v = ~cur;
    end
    return v;
  endfunction

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Write happens once address and data are both held
  // The write strobe lasts one cycle: bvalid rises on the edge that
  // lands the write, which closes do_write behind it.
  // A cleared low byte lane turns a write to a mapped register into a no-op with OKAY.
  wire       do_write = aw_full && w_full && !bvalid;
  wire       wr_ok    = do_write && w_lane0;
  wire [7:0] wbyte    = w_data[7:0];
  wire       wr_ctrl_a = wr_ok && aw_index == IDX_CONTROL_A;
  wire       wr_ctrl_b = wr_ok && aw_index == IDX_CONTROL_B;
  wire       wr_count  = wr_ok && aw_index == IDX_COUNT;
  wire       wr_cmp_a  = wr_ok && aw_index == IDX_COMPARE_A;
  wire       wr_cmp_b  = wr_ok && aw_index == IDX_COMPARE_B;
  wire       wr_mask   = wr_ok && aw_index == IDX_MASK;
  wire       wr_flags  = wr_ok && aw_index == IDX_FLAGS;
  wire       wr_global = wr_ok && aw_index == IDX_GLOBAL;
  wire       aw_mapped = aw_index >= IDX_CONTROL_A && aw_index <= IDX_GLOBAL;
  wire [5:0] ar_index  = araddr[7:2];

  // Read multiplexer; unused and reserved bits read as zero
  // It looks at araddr live, so the address must stand until the
  // edge that takes it, as the bus rules demand.
  wire [7:0] rd_byte =
    (ar_index == IDX_CONTROL_A) ? {2'h0, ctrl_a} :
    (ar_index == IDX_CONTROL_B) ? {4'h0, ctrl_b} :
    (ar_index == IDX_COUNT)     ? count_value :
    (ar_index == IDX_COMPARE_A) ? compare_value_a :
    (ar_index == IDX_COMPARE_B) ? compare_value_b :
    (ar_index == IDX_MASK)      ? {5'h00, interrupt_mask} :
    (ar_index == IDX_FLAGS)     ? {5'h00, interrupt_flags} :
    (ar_index == IDX_GLOBAL)    ? {7'h00, global_irq_enable} :
    RESET_BYTE;
  wire ar_mapped = ar_index >= IDX_CONTROL_A && ar_index <= IDX_GLOBAL;

  // ----------------------------------------------------------------
  // Mode and clock selection
  // ----------------------------------------------------------------
  // Three-bit mode from both control registers
  // Odd modes are PWM; 1 and 5 count up and down, 3 and 7 wrap.
  // Modes 2, 5 and 7 take their top from compare register A;
  // modes 4 and 6 are reserved and count like mode 0.
  wire [2:0] mode      = {ctrl_b.wave_mode_high_bit,
                          ctrl_a.wave_mode_low_bits};
  wire       pwm       = mode[0];
  wire       phase     = mode[0] && !mode[1];
  wire       top_cmp_a = mode == 3'd2 || mode == 3'd5 || mode == 3'd7;
  wire [7:0] top       = top_cmp_a ? compare_value_a : COUNT_MAX;

  // Pin edges seen at the input, whatever the pin direction
  // The history flop resets low but loads the pin on the first edge after release,
  // before any source can be chosen, so a pin already high at release never counts.
  wire pin_fall = pin_prev && !external_count_pin;
  wire pin_rise = !pin_prev && external_count_pin;

  // ----------------------------------------------------------------
  // Prescaler taps
  // ----------------------------------------------------------------
  // One pulse per division period; all taps share one counter, so a
  // source change never waits for a reload
  wire tap_8    = (prescale & DIV_8) == DIV_8;
  wire tap_64   = (prescale & DIV_64) == DIV_64;
  wire tap_256  = (prescale & DIV_256) == DIV_256;
  wire tap_1024 = prescale == DIV_1024;

  // Timer clock enable from the selected source
  // Only one source is live at a time; stop gives no tick at all.
  wire tick =
    (ctrl_b.clock_source_select == SRC_DIV1)    ? 1'b1 :
    (ctrl_b.clock_source_select == SRC_DIV8)    ? tap_8 :
    (ctrl_b.clock_source_select == SRC_DIV64)   ? tap_64 :
    (ctrl_b.clock_source_select == SRC_DIV256)  ? tap_256 :
    (ctrl_b.clock_source_select == SRC_DIV1024) ? tap_1024 :
    (ctrl_b.clock_source_select == SRC_FALL)    ? pin_fall :
    (ctrl_b.clock_source_select == SRC_RISE)    ? pin_rise :
    1'b0;

  // ----------------------------------------------------------------
  // Counter and compare
  // ----------------------------------------------------------------
  // Matches are judged on a timer clock unless a counter write blocks it
  // The block lives for one timer clock: the tick after the software
  // write clears it whatever the match result.
  wire at_top   = count_value == top;
  wire match_a  = tick && !block_match && count_value == compare_value_a;
  wire match_b  = tick && !block_match && count_value == compare_value_b;
  wire turn     = count_down ? count_value == COUNT_MIN : at_top;
  wire next_count_down = phase ? count_down ^ turn : 1'b0;
  wire [7:0] next_step =
    phase ? (next_count_down ? count_value - 8'h01 : count_value + 8'h01) :
    at_top ? COUNT_MIN : count_value + 8'h01;
  wire fast_bottom = tick && pwm && !phase && at_top;

  // Overflow point depends on the mode
  // Phase correct modes flag the turn at bottom, mode 7 the wrap at
  // the compare A top, all others the pass through the maximum.
  wire overflow_evt = tick && (phase ? count_down && count_value == COUNT_MIN :
                               mode == 3'd7 ? at_top :
                               count_value == COUNT_MAX);

  // Force strobes act only outside PWM modes and never touch flags
  // They feed the waveform step only, so a forced hit never clears
  // the counter, even where compare A sets the top.
  wire force_a = wr_ctrl_b && wbyte[FORCE_A_POS] && !pwm;
  wire force_b = wr_ctrl_b && wbyte[FORCE_B_POS] && !pwm;

  // Flag events: set wins over both clears
  // A vector clear and a software clear may land together; a hit in
  // the same cycle still leaves its flag set.
  irq_bits_type set_evt;
  irq_bits_type clr_evt;
  irq_bits_type next_flags;
  assign set_evt    = '{match_b: match_b, match_a: match_a,
                        overflow: overflow_evt};
  assign clr_evt    = vector_done | (wr_flags ? irq_bits_type'(wbyte[2:0]) :
                                     irq_bits_type'(3'h0));
  assign next_flags = set_evt | (interrupt_flags & ~clr_evt);

  // Interrupt line follows the flags as they stand after this edge
  wire next_irq = global_irq_enable && |(next_flags & interrupt_mask);

  // Channel B never toggles in PWM; its action 01 is reserved there
  wire next_wave_a = wave_next(wave_out_a, ctrl_a.output_action_a,
                               match_a || force_a, fast_bottom,
                               next_count_down, pwm, mode[2]);
  wire next_wave_b = wave_next(wave_out_b, ctrl_a.output_action_b,
                               match_b || force_b, fast_bottom,
                               next_count_down, pwm, 1'b0);

  // ----------------------------------------------------------------
  // Registers written by software
  // ----------------------------------------------------------------
  // Control, compare, mask and global enable
  // Stored fields only: force strobes and reserved bits are dropped
  // here, so they can never be read back.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_a            <= '0;
      ctrl_b            <= '0;
      compare_value_a   <= RESET_BYTE;
      compare_value_b   <= RESET_BYTE;
      interrupt_mask    <= '0;
      global_irq_enable <= 1'b0;
    end else begin
      if (wr_ctrl_a) ctrl_a <= control_a_type'(wbyte[5:0]);
      if (wr_ctrl_b) ctrl_b <= control_b_type'(wbyte[3:0]);
      if (wr_cmp_a) compare_value_a <= wbyte;
      if (wr_cmp_b) compare_value_b <= wbyte;
      if (wr_mask) interrupt_mask <= irq_bits_type'(wbyte[2:0]);
      if (wr_global) global_irq_enable <= wbyte[GLOBAL_EN_POS];
    end
  end

  // ----------------------------------------------------------------
  // Timer core
  // ----------------------------------------------------------------
  // Counter, direction and match blocking; software write wins
  // A software write outranks a timer clock in the same cycle, so the
  // written value is loaded unstepped and the step of that tick is lost.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_value <= RESET_BYTE;
      count_down  <= 1'b0;
      block_match <= 1'b0;
    end else if (wr_count) begin
      count_value <= wbyte;
      block_match <= 1'b1;
    end else if (tick) begin
      count_value <= next_step;
      count_down  <= next_count_down;
      block_match <= 1'b0;
    end
  end

  // Prescaler and pin history
  // The prescaler never stops, which makes every tap periodic and
  // lets a count window be any multiple of the chosen division.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prescale <= 10'h000;
      pin_prev <= 1'b0;
    end else begin
      prescale <= prescale + 10'h001;
      pin_prev <= external_count_pin;
    end
  end

  // Flags, interrupt line and waveform outputs
  // Flags and irq share one edge; the line never lags its flag.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      interrupt_flags <= '0;
      irq             <= 1'b0;
      wave_out_a      <= 1'b0;
      wave_out_b      <= 1'b0;
    end else begin
      interrupt_flags <= next_flags;
      irq             <= next_irq;
      wave_out_a      <= next_wave_a;
      wave_out_b      <= next_wave_b;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  // Address and data taken in either order, answer after both
  // awready and wready stay low from acceptance until one cycle after
  // the response handshake, so at most one write is under way.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready  <= 1'b0;
      wready   <= 1'b0;
      aw_full  <= 1'b0;
      w_full   <= 1'b0;
      aw_index <= 6'h00;
      w_data   <= 32'h0000_0000;
      w_lane0  <= 1'b0;
      bvalid   <= 1'b0;
      bresp    <= RESP_OKAY;
    end else begin
      awready <= !aw_full && !(awvalid && awready);
      wready  <= !w_full && !(wvalid && wready);
      if (awvalid && awready) begin
        aw_full  <= 1'b1;
        aw_index <= awaddr[7:2];
      end
      if (wvalid && wready) begin
        w_full  <= 1'b1;
        w_data  <= wdata;
        w_lane0 <= wstrb[0];
      end
      if (do_write) begin
        bvalid <= 1'b1;
        bresp  <= aw_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid  <= 1'b0;
        aw_full <= 1'b0;
        w_full  <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  // One read at a time; data registered on the address handshake
  // Data are captured with the address, so later timer activity
  // cannot change a value already on its way back.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= {24'h000000, rd_byte};
      rresp   <= ar_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end else begin
      arready <= !rvalid;
    end
  end

endmodule

// File: hdl/timer8_pkg.sv
// Constants and types of the 8-bit timer with its register block.
// Assumes a 32-bit AXI4-Lite master; byte address is four times an index.
package timer8_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_CONTROL_A = 6'h24;
  localparam logic [5:0] IDX_CONTROL_B = 6'h25;
  localparam logic [5:0] IDX_COUNT     = 6'h26;
  localparam logic [5:0] IDX_COMPARE_A = 6'h27;
  localparam logic [5:0] IDX_COMPARE_B = 6'h28;
  localparam logic [5:0] IDX_MASK      = 6'h29;
  localparam logic [5:0] IDX_FLAGS     = 6'h2a;
  localparam logic [5:0] IDX_GLOBAL    = 6'h2b;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FORCE_A_POS   = 7;
  localparam int FORCE_B_POS   = 6;
  localparam int OVERFLOW_POS  = 0;
  localparam int MATCH_A_POS   = 1;
  localparam int MATCH_B_POS   = 2;
  localparam int GLOBAL_EN_POS = 0;

  // ----------------------------------------------------------------
  // Values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] COUNT_MAX  = 8'hff;
  localparam logic [7:0] COUNT_MIN  = 8'h00;
  localparam logic [9:0] DIV_8      = 10'h007;
  localparam logic [9:0] DIV_64     = 10'h03f;
  localparam logic [9:0] DIV_256    = 10'h0ff;
  localparam logic [9:0] DIV_1024   = 10'h3ff;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Clock source codes
  typedef enum logic [2:0] {
    SRC_STOP  = 3'b000,
    SRC_DIV1  = 3'b001,
    SRC_DIV8  = 3'b010,
    SRC_DIV64 = 3'b011,
    SRC_DIV256 = 3'b100,
    SRC_DIV1024 = 3'b101,
    SRC_FALL  = 3'b110,
    SRC_RISE  = 3'b111
  } clock_source_type;

  // Control register A fields
  typedef struct packed {
    logic [1:0] output_action_a;
    logic [1:0] output_action_b;
    logic [1:0] wave_mode_low_bits;
  } control_a_type;

  // Control register B stored fields
  typedef struct packed {
    logic             wave_mode_high_bit;
    clock_source_type clock_source_select;
  } control_b_type;

  // Interrupt bits: match B, match A, overflow
  typedef struct packed {
    logic match_b;
    logic match_a;
    logic overflow;
  } irq_bits_type;

endpackage

// File: sim/timer8_asserts.sv
// Checker of the timer8 bus handshakes, read values and quiet outputs.
// Assumes binding to timer8; sees only its ports.
`timescale 1ns/100ps
module timer8_asserts
  import timer8_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [7:0]  araddr,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic        wave_out_a,
  input wire logic        wave_out_b,
  input wire logic        irq
);
  logic [5:0] rd_idx;
  logic       mapped;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Index of the read under way
  always_ff @(posedge aclk) begin
    if (!aresetn) rd_idx <= 6'h00;
    else if (arvalid && arready) rd_idx <= araddr[7:2];
  end
  assign mapped = (rd_idx >= IDX_CONTROL_A) && (rd_idx <= IDX_GLOBAL);

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  write_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write response late");
  write_done_a: assert property (bvalid && bready |=> !bvalid && !awready)
    else $error("write response held");
  read_answer_a: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read data late");
  read_done_a: assert property (rvalid && rready |=> !rvalid)
    else $error("read data held");
  force_zero_a: assert property (rvalid && rd_idx == IDX_CONTROL_B |-> rdata[7:4] == 4'h0)
    else $error("control b high bits set");
  flag_rsvd_a: assert property (rvalid && rd_idx >= IDX_MASK && rd_idx <= IDX_FLAGS
    |-> rdata[31:3] == 29'h0)
    else $error("reserved mask or flag bits set");
  resp_code_a: assert property (rvalid |-> rresp == (mapped ? RESP_OKAY : RESP_SLVERR))
    else $error("read response code wrong");
  reset_quiet_a: assert property ($rose(aresetn) |-> !irq && !wave_out_a && !wave_out_b)
    else $error("outputs active after reset");

  // Main scenarios
  cover property (awvalid && awready);
  cover property ($rose(irq));
  cover property ($changed(wave_out_a));
endmodule

// File: sim/timer8_test.sv
// Self-checking bench of timer8: registers, flags, irq, force, pin count.
// Assumes the bench is the only bus master and drives every port.
`timescale 1ns/100ps
module timer8_test;
  import timer8_pkg::*;
  logic         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic         external_count_pin, awready, wready, bvalid, arready, rvalid;
  logic         wave_out_a, wave_out_b, irq, w0, w1;
  logic [7:0]   awaddr, araddr;
  logic [31:0]  wdata, rdata, v;
  logic [3:0]   wstrb;
  logic [1:0]   bresp, rresp, r;
  irq_bits_type vector_done;
  int           err_count, n_tests, cycles;

  timer8 i_timer8 (.*);

  // --------------------------------------------------------------
  // Clock, timeout, verdict
  // --------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // Cut a hang short
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      complete_run;
    end
  end

  task complete_run;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", s, e, g);
      err_count++;
    end
  endtask

  // --------------------------------------------------------------
  // Bus and pin tasks
  // --------------------------------------------------------------
  task wr(input logic [5:0] i, input logic [7:0] d);
    @(posedge aclk);
    awaddr <= {i, 2'b00};
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  task rd(input logic [5:0] i);
    @(posedge aclk);
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task rchk(input logic [5:0] i, input logic [31:0] e, input string s);
    rd(i);
    chk(s, e, v);
  endtask

  task pin(input logic l);
    @(posedge aclk) external_count_pin <= l;
    repeat (3) @(posedge aclk);
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task t_regs;
    rchk(IDX_CONTROL_A, 32'h0, "ctl a reset");
    rchk(IDX_CONTROL_B, 32'h0, "ctl b reset");
    rchk(IDX_COMPARE_A, 32'h0, "cmp a reset");
    rchk(IDX_COMPARE_B, 32'h0, "cmp b reset");
    rchk(IDX_MASK, 32'h0, "mask reset");
    rchk(IDX_FLAGS, 32'h0, "flags reset");
    wr(IDX_CONTROL_B, 8'hf8);
    rchk(IDX_CONTROL_B, 32'h08, "ctl b read");
    wr(IDX_CONTROL_B, 8'h00);
    wr(IDX_MASK, 8'hff);
    rchk(IDX_MASK, 32'h07, "mask read");
    wr(IDX_COUNT, 8'h3c);
    rchk(IDX_COUNT, 32'h3c, "count rw");
    wr(6'h30, 8'h11);
    chk("unmapped wr", 32'(RESP_SLVERR), 32'(r));
    rd(6'h30);
    chk("unmapped rd", 32'(RESP_SLVERR), 32'(r));
  endtask

  task t_match;
    wr(IDX_MASK, 8'h02);
    wr(IDX_COMPARE_A, 8'h20);
    wr(IDX_COMPARE_B, 8'h80);
    wr(IDX_COUNT, 8'h00);
    wr(IDX_GLOBAL, 8'h01);
    wr(IDX_CONTROL_B, 8'h01);
    do rd(IDX_FLAGS); while (!v[MATCH_A_POS]);
    @(posedge aclk);
    chk("irq on", 32'h1, 32'(irq));
    do rd(IDX_FLAGS); while (!v[OVERFLOW_POS]);
    wr(IDX_CONTROL_B, 8'h00);
    rchk(IDX_FLAGS, 32'h07, "all flags");
    wr(IDX_FLAGS, 8'h00);
    rchk(IDX_FLAGS, 32'h07, "zero keeps");
    wr(IDX_FLAGS, 8'h02);
    @(posedge aclk);
    chk("irq masked", 32'h0, 32'(irq));
    rchk(IDX_FLAGS, 32'h05, "one clears");
    @(posedge aclk) vector_done <= irq_bits_type'(3'b001);
    @(posedge aclk) vector_done <= irq_bits_type'(3'b000);
    rchk(IDX_FLAGS, 32'h04, "vector clear");
    wr(IDX_FLAGS, 8'h04);
  endtask

  task t_block;
    wr(IDX_COUNT, 8'h00);
    wr(IDX_CONTROL_B, 8'h01);
    wr(IDX_COUNT, 8'h20);
    wr(IDX_CONTROL_B, 8'h00);
    rchk(IDX_FLAGS, 32'h0, "match blocked");
  endtask

  task t_force;
    wr(IDX_CONTROL_A, 8'h14);
    w0 = wave_out_a;
    w1 = wave_out_b;
    wr(IDX_CONTROL_B, 8'hc0);
    chk("force a", {31'h0, ~w0}, {31'h0, wave_out_a});
    chk("force b", {31'h0, ~w1}, {31'h0, wave_out_b});
    rchk(IDX_FLAGS, 32'h0, "force flags");
    chk("force irq", 32'h0, 32'(irq));
    // Fast PWM, channel A clears on a hit: a wrongly taken force would show
    wr(IDX_CONTROL_A, 8'h23);
    w0 = wave_out_a;
    wr(IDX_CONTROL_B, 8'h80);
    chk("pwm force", 32'(w0), 32'(wave_out_a));
    wr(IDX_CONTROL_B, 8'h00);
    wr(IDX_CONTROL_A, 8'h00);
  endtask

  // Run for w edges from the landing of the start write to that of the
  // stop write; each write lands two edges after it is offered
  task run_for(input logic [7:0] ctl_a, input logic [7:0] ctl_b, input int w);
    wr(IDX_COUNT, 8'h00);
    wr(IDX_CONTROL_A, ctl_a);
    wr(IDX_CONTROL_B, ctl_b);
    repeat (w - 4) @(posedge aclk);
    wr(IDX_CONTROL_B, 8'h00);
  endtask

  // Top and overflow point in clear-on-match, fast and phase correct PWM
  task t_modes;
    wr(IDX_COMPARE_A, 8'h10);
    wr(IDX_FLAGS, 8'h07);
    run_for(8'h02, 8'h01, 20);
    rchk(IDX_COUNT, 32'h03, "ctc count");
    rchk(IDX_FLAGS, 32'h02, "ctc flags");
    wr(IDX_FLAGS, 8'h07);
    run_for(8'h03, 8'h09, 20);
    rchk(IDX_COUNT, 32'h03, "top count");
    rchk(IDX_FLAGS, 32'h03, "top flags");
    wr(IDX_FLAGS, 8'h07);
    run_for(8'h01, 8'h09, 40);
    rchk(IDX_COUNT, 32'h08, "phase count");
    rchk(IDX_FLAGS, 32'h03, "phase flags");
    wr(IDX_FLAGS, 8'h07);
    wr(IDX_CONTROL_A, 8'h00);
  endtask

  // Prescaled clock over a window: w edges give w / division ticks
  task t_scale(input logic [7:0] code, input int w, input logic [7:0] e, input string s);
    run_for(8'h00, code, w);
    rchk(IDX_COUNT, {24'h000000, e}, s);
  endtask

  task t_ext;
    wr(IDX_COUNT, 8'h00);
    wr(IDX_CONTROL_B, 8'h07);
    repeat (3) begin
      pin(1'b1);
      pin(1'b0);
    end
    rchk(IDX_COUNT, 32'h03, "rise count");
    wr(IDX_CONTROL_B, 8'h06);
    pin(1'b1);
    rchk(IDX_COUNT, 32'h03, "fall only");
    pin(1'b0);
    rchk(IDX_COUNT, 32'h04, "fall count");
    wr(IDX_CONTROL_B, 8'h00);
  endtask

  // Reset, then the scenarios in turn
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, external_count_pin} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hf;
    vector_done = '0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs;
    t_match;
    t_block;
    t_force;
    t_modes;
    t_scale(8'h02, 128, 8'h10, "div 8");
    t_scale(8'h03, 256, 8'h04, "div 64");
    t_scale(8'h04, 512, 8'h02, "div 256");
    t_scale(8'h05, 2048, 8'h02, "div 1024");
    t_ext;
    complete_run;
  end
endmodule

bind timer8 timer8_asserts i_timer8_asserts (.*);
